/* shared/vst_consts.vh */
// constants shared by the vlan stacking tagger and its output fifo
`ifndef VST_CONSTS_VH
`define VST_CONSTS_VH

// ----------------------------------------------------------------
// port stacking roles
// ----------------------------------------------------------------
`define VST_ROLE_NORMAL 2'h0
`define VST_ROLE_ACCESS 2'h1
`define VST_ROLE_TUNNEL 2'h2

// ----------------------------------------------------------------
// tag type values and the outer tag type table
// ----------------------------------------------------------------
`define VST_CUST_TPID 16'h8100
`define VST_TPID_RESET 16'h8100
`define VST_TPID_ENTRIES 6
`define VST_TPID_IDX_W 3

// ----------------------------------------------------------------
// byte offsets inside the frame header
// ----------------------------------------------------------------
`define VST_SA_END 5'h0c
`define VST_TYPE1_OFS 5'h0c
`define VST_TCI1_OFS 5'h0e
`define VST_TYPE2_OFS 5'h10
`define VST_INNER_OFS 5'h10
`define VST_TAG_LEN 5'h04
`define VST_HDR_LEN 5'h16
`define VST_HDR_OUT_BASE 5'h16

// ----------------------------------------------------------------
// tag control field layout, priority 0 lowest, 7 highest
// ----------------------------------------------------------------
`define VST_PRI_W 3
`define VST_VID_W 12
`define VST_DEI_VALUE 1'h0

// ----------------------------------------------------------------
// frame check sequence
// ----------------------------------------------------------------
`define VST_CRC_INIT 32'hffff_ffff
`define VST_CRC_POLY 32'hedb8_8320
`define VST_FCS_LAST 2'h3

// ----------------------------------------------------------------
// output buffer shape
// ----------------------------------------------------------------
`define VST_FIFO_DEPTH 16
`define VST_FIFO_WIDTH 9

`endif

/* rtl/vst_fifo.v */
// synchronous byte fifo with a registered read stage
`timescale 1ns/1ps
module vst_fifo #(
    parameter WIDTH = 9,
    parameter DEPTH = 16,
    parameter AW = 4
) (
    input wire clk,                 // core clock
    input wire reset,               // synchronous, active high
    input wire [WIDTH-1:0] wr_data, // word to store
    input wire wr_valid,            // store request
    output wire wr_ready,           // room for one more word
    output wire [WIDTH-1:0] rd_data,// head word
    output wire rd_valid,           // head word present
    input wire rd_ready,            // sink takes head word
    output wire [AW:0] count        // words held in the array
);
    reg [WIDTH-1:0] mem [0:DEPTH-1];
    reg [AW-1:0] wr_ptr_reg;
    reg [AW-1:0] rd_ptr_reg;
    reg [AW:0] count_reg;
    reg [WIDTH-1:0] rd_data_reg;
    reg rd_valid_reg;
    wire push;
    wire pop;

    // full and empty from the held count
    assign wr_ready = (count_reg < DEPTH);
    assign push = wr_valid && wr_ready;
    assign pop = (count_reg != 0) && (!rd_valid_reg || rd_ready);
    assign rd_data = rd_data_reg;
    assign rd_valid = rd_valid_reg;
    assign count = count_reg;

    // array write
    always @(posedge clk) begin
        if (push) begin
            mem[wr_ptr_reg] <= wr_data;
        end
    end

    // pointers, count and the output stage
    always @(posedge clk) begin
        if (reset) begin
            wr_ptr_reg <= {AW{1'b0}};
            rd_ptr_reg <= {AW{1'b0}};
            count_reg <= {(AW+1){1'b0}};
            rd_data_reg <= {WIDTH{1'b0}};
            rd_valid_reg <= 1'b0;
        end else begin
            if (push) begin
                wr_ptr_reg <= wr_ptr_reg + 1'b1;
            end
            if (pop) begin
                rd_ptr_reg <= rd_ptr_reg + 1'b1;
                rd_data_reg <= mem[rd_ptr_reg];
                rd_valid_reg <= 1'b1;
            end else if (rd_ready) begin
                rd_valid_reg <= 1'b0;
            end
            if (push && !pop) begin
                count_reg <= count_reg + 1'b1;
            end else if (pop && !push) begin
                count_reg <= count_reg - 1'b1;
            end
        end
    end
endmodule

/* rtl/vst_tagger.v */
// vlan stacking tagger: classifies, tags or strips and re-checksums one frame path
// Overview of operation
// - each port holds one role: normal, customer access, or provider tunnel
// - tunnel egress sends every frame with outer service tag, vid and priority
// - tunnel ingress takes double, single or untagged frames, all keyed on a service vid
// - access ingress takes only single customer tagged or untagged frames
// - access egress inserts no service tag; frames leave with whatever tags ingress kept
// - normal ports switch single tagged frames and drop double tagged ones
// - access ingress frames count as untagged so the outer tag goes ahead
// - every tag is type identifier, then priority, then vlan identifier
// - customer tag type is 0x8100; outer tag type is configurable, e.g. 0x9100
// - tunnel egress outer tag uses the configured outer tag type value
// - priority 0 is lowest and 7 is highest
// - outer tag holds service vid, inner holds customer vid, outer follows source address
// - ingress provider edge inserts the outer service tag
// - destination provider edge removes the outer tag toward the customer
// - forwarding uses destination address and vid like any physical port frame
// - double tagged frames switch on service vid; membership covers tunnel and access ports
// - tunnel ports are tagged members, access ports untagged members of service vlan
// - each tunnel port picks its outer tag type from a six entry table
`timescale 1ns/1ps
`include "vst_consts.vh"
module vst_tagger #(
    parameter FIFO_DEPTH = `VST_FIFO_DEPTH,
    parameter FIFO_AW = 4
) (
    input wire clk,                                   // core clock
    input wire reset,                                 // synchronous, active high
    input wire [1:0] in_role,                         // stacking role of ingress port
    input wire [1:0] out_role,                        // stacking role of egress port
    input wire [`VST_TPID_IDX_W-1:0] in_tpid_index,   // outer type table entry, ingress port
    input wire [`VST_TPID_IDX_W-1:0] out_tpid_index,  // outer type table entry, egress port
    input wire [`VST_VID_W-1:0] port_vid,             // default vid of ingress port
    input wire [`VST_VID_W-1:0] service_vlan_id,      // service vid of ingress port
    input wire [`VST_PRI_W-1:0] service_pri,          // service priority of ingress port
    input wire egress_member,                         // egress port is member of the forwarding vlan
    input wire tpid_wr,                               // write pulse for the type table
    input wire [`VST_TPID_IDX_W-1:0] tpid_wr_index,   // table entry to write, 1 to 5
    input wire [15:0] tpid_wr_value,                  // new outer tag type value
    input wire [7:0] in_data,                         // frame byte, no check sequence
    input wire in_valid,                              // frame byte present
    input wire in_last,                               // last byte of frame
    output wire in_ready,                             // byte taken this cycle
    output wire [7:0] out_data,                       // rebuilt frame byte
    output wire out_valid,                            // rebuilt byte present
    output wire out_last,                             // last check sequence byte
    input wire out_ready,                             // sink takes byte
    output wire fwd_valid,                            // forwarding key pulse
    output wire [47:0] fwd_da,                        // destination address
    output wire [`VST_VID_W-1:0] fwd_vid,             // vid used for the lookup
    output wire [`VST_PRI_W-1:0] fwd_pri,             // priority of the frame
    output wire fwd_double,                           // frame was stacked
    output wire drop_pulse                            // frame discarded
);
    // ----------------------------------------------------------------
    // states
    // ----------------------------------------------------------------
    localparam [5:0] S_CAP = 6'h01;
    localparam [5:0] S_DECIDE = 6'h02;
    localparam [5:0] S_EMIT = 6'h04;
    localparam [5:0] S_BODY = 6'h08;
    localparam [5:0] S_FCS = 6'h10;
    localparam [5:0] S_DROP = 6'h20;

    // ----------------------------------------------------------------
    // functions
    // ----------------------------------------------------------------
    // one byte of the reflected crc32
    function [31:0] vst_crc_byte;
        input [31:0] crc;
        input [7:0] data;
        integer i;
        reg [31:0] r;
        begin
            r = crc ^ {24'h0000_00, data};
            for (i = 0; i < 8; i = i + 1) begin
                r = r[0] ? ((r >> 1) ^ `VST_CRC_POLY) : (r >> 1);
            end
            vst_crc_byte = r;
        end
    endfunction

    // byte k of a tag: type high, type low, priority and vid high, vid low
    function [7:0] vst_tag_byte;
        input [15:0] tpid;
        input [`VST_PRI_W-1:0] pri;
        input [`VST_VID_W-1:0] vid;
        input [1:0] k;
        begin
            case (k)
                2'h0: vst_tag_byte = tpid[15:8];
                2'h1: vst_tag_byte = tpid[7:0];
                2'h2: vst_tag_byte = {pri, `VST_DEI_VALUE, vid[11:8]};
                default: vst_tag_byte = vid[7:0];
            endcase
        end
    endfunction

    // ----------------------------------------------------------------
    // storage
    // ----------------------------------------------------------------
    reg [15:0] tpid_tab [0:`VST_TPID_ENTRIES-1];
    reg [7:0] hdr [0:`VST_HDR_LEN-1];
    reg [5:0] state_reg;
    reg [5:0] state_next;
    reg [4:0] cap_cnt_reg;
    reg hdr_last_reg;
    reg [4:0] emit_pos_reg;
    reg [4:0] emit_len_reg;
    reg [4:0] keep_reg;
    reg ins_reg;
    reg [15:0] out_tpid_reg;
    reg [`VST_VID_W-1:0] svc_vid_reg;
    reg [`VST_PRI_W-1:0] svc_pri_reg;
    reg [31:0] crc_reg;
    reg [1:0] fcs_cnt_reg;
    reg in_ready_reg;
    reg fwd_valid_reg;
    reg [47:0] fwd_da_reg;
    reg [`VST_VID_W-1:0] fwd_vid_reg;
    reg [`VST_PRI_W-1:0] fwd_pri_reg;
    reg fwd_double_reg;
    reg drop_reg;
    integer t;

    // ----------------------------------------------------------------
    // outer tag type table
    // ----------------------------------------------------------------
    // entry 0 stays the customer type, the rest are writable
    always @(posedge clk) begin
        if (reset) begin
            for (t = 0; t < `VST_TPID_ENTRIES; t = t + 1) begin
                tpid_tab[t] <= `VST_TPID_RESET;
            end
        end else if (tpid_wr && tpid_wr_index != 0 && tpid_wr_index < `VST_TPID_ENTRIES) begin
            tpid_tab[tpid_wr_index] <= tpid_wr_value;
        end
    end

    // ----------------------------------------------------------------
    // header classification
    // ----------------------------------------------------------------
    wire [15:0] type1 = {hdr[`VST_TYPE1_OFS], hdr[`VST_TYPE1_OFS+1]};
    wire [15:0] type2 = {hdr[`VST_TYPE2_OFS], hdr[`VST_TYPE2_OFS+1]};
    wire [15:0] in_tpid = (in_tpid_index < `VST_TPID_ENTRIES) ? tpid_tab[in_tpid_index] : `VST_CUST_TPID;
    wire [15:0] out_tpid = (out_tpid_index < `VST_TPID_ENTRIES) ? tpid_tab[out_tpid_index] : `VST_CUST_TPID;
    // first tag fields: type, priority, vid
    wire [`VST_PRI_W-1:0] pri1 = hdr[`VST_TCI1_OFS][7:5];
    wire [`VST_VID_W-1:0] vid1 = {hdr[`VST_TCI1_OFS][3:0], hdr[`VST_TCI1_OFS+1]};
    wire cust1 = (type1 == `VST_CUST_TPID);
    wire outer1 = (type1 == in_tpid);
    wire tag1 = cust1 || outer1;
    wire tag2 = tag1 && (type2 == `VST_CUST_TPID || type2 == in_tpid);
    // leading tag is a service tag
    wire in_svc = tag2 || (outer1 && !cust1);
    wire role_access = (in_role == `VST_ROLE_ACCESS);
    wire role_tunnel = (in_role == `VST_ROLE_TUNNEL);
    wire stacked = role_access || role_tunnel;
    wire strip = role_tunnel && in_svc;

    reg drop_c;
    reg [`VST_VID_W-1:0] key_vid_c;
    reg [`VST_PRI_W-1:0] key_pri_c;

    // acceptance and lookup key per ingress role
    always @* begin
        drop_c = !egress_member;
        key_vid_c = tag1 ? vid1 : port_vid;
        key_pri_c = tag1 ? pri1 : service_pri;
        case (in_role)
            `VST_ROLE_ACCESS: begin
                // customer frames are untagged for stacking, port service tag applies
                if (tag2 || (tag1 && !cust1)) drop_c = 1'b1;
                key_vid_c = service_vlan_id;
                key_pri_c = service_pri;
            end
            `VST_ROLE_TUNNEL: begin
                // every tag shape is taken, service tag comes from frame or port
                key_vid_c = in_svc ? vid1 : service_vlan_id;
                key_pri_c = in_svc ? pri1 : service_pri;
            end
            default: if (tag2) drop_c = 1'b1;
        endcase
    end

    // ----------------------------------------------------------------
    // output buffer
    // ----------------------------------------------------------------
    reg [7:0] wr_byte_c;
    reg wr_last_c;
    reg wr_valid_c;
    wire fifo_wr_ready;
    wire [FIFO_AW:0] fifo_count;
    wire [`VST_FIFO_WIDTH-1:0] fifo_rd_data;
    wire in_take = in_valid && in_ready_reg;

    vst_fifo #(
        .WIDTH(`VST_FIFO_WIDTH),
        .DEPTH(FIFO_DEPTH),
        .AW(FIFO_AW)
    ) u_fifo (
        .clk(clk),
        .reset(reset),
        .wr_data({wr_last_c, wr_byte_c}),
        .wr_valid(wr_valid_c),
        .wr_ready(fifo_wr_ready),
        .rd_data(fifo_rd_data),
        .rd_valid(out_valid),
        .rd_ready(out_ready),
        .count(fifo_count)
    );

    assign out_data = fifo_rd_data[7:0];
    assign out_last = fifo_rd_data[8];

    // ----------------------------------------------------------------
    // rebuilt header byte selection
    // ----------------------------------------------------------------
    wire [4:0] ins_len = ins_reg ? `VST_TAG_LEN : 5'h00;
    wire [4:0] src_idx = emit_pos_reg + keep_reg - `VST_SA_END - ins_len;
    wire [4:0] tag_k = emit_pos_reg - `VST_SA_END;
    reg [7:0] hdr_byte_c;

    // addresses, then the outer tag right after the source address, then the kept bytes
    always @* begin
        if (emit_pos_reg < `VST_SA_END) begin
            hdr_byte_c = hdr[emit_pos_reg];
        end else if (ins_reg && emit_pos_reg < `VST_SA_END + `VST_TAG_LEN) begin
            hdr_byte_c = vst_tag_byte(out_tpid_reg, svc_pri_reg, svc_vid_reg, tag_k[1:0]);
        end else begin
            hdr_byte_c = hdr[src_idx];
        end
    end

    // ----------------------------------------------------------------
    // buffer write port
    // ----------------------------------------------------------------
    wire [31:0] fcs_word = ~crc_reg;

    always @* begin
        wr_valid_c = 1'b0;
        wr_byte_c = 8'h00;
        wr_last_c = 1'b0;
        case (state_reg)
            S_EMIT: begin
                wr_valid_c = 1'b1;
                wr_byte_c = hdr_byte_c;
            end
            S_BODY: begin
                wr_valid_c = in_take;
                wr_byte_c = in_data;
            end
            S_FCS: begin
                // check sequence leaves low byte first
                wr_valid_c = 1'b1;
                wr_byte_c = fcs_word[8*fcs_cnt_reg +: 8];
                wr_last_c = (fcs_cnt_reg == `VST_FCS_LAST);
            end
            default: wr_valid_c = 1'b0;
        endcase
    end

    wire wr_go = wr_valid_c && fifo_wr_ready;

    // ----------------------------------------------------------------
    // frame sequencer
    // ----------------------------------------------------------------
    always @* begin
        state_next = state_reg;
        case (state_reg)
            S_CAP: if (in_take && cap_cnt_reg == `VST_HDR_LEN - 1) state_next = S_DECIDE;
            S_DECIDE: state_next = drop_c ? (hdr_last_reg ? S_CAP : S_DROP) : S_EMIT;
            S_EMIT: if (wr_go && emit_pos_reg == emit_len_reg - 1'b1) state_next = hdr_last_reg ? S_FCS : S_BODY;
            S_BODY: if (wr_go && in_last) state_next = S_FCS;
            S_FCS: if (wr_go && fcs_cnt_reg == `VST_FCS_LAST) state_next = S_CAP;
            S_DROP: if (in_take && in_last) state_next = S_CAP;
            default: state_next = S_CAP;
        endcase
    end

    // input is ready with room for one byte already in flight
    wire body_room = (fifo_count < FIFO_DEPTH - 2);

    // state, header capture, emit counters and checksum
    always @(posedge clk) begin
        if (reset) begin
            state_reg <= S_CAP;
            cap_cnt_reg <= 5'h00;
            hdr_last_reg <= 1'b0;
            emit_pos_reg <= 5'h00;
            emit_len_reg <= 5'h00;
            keep_reg <= `VST_SA_END;
            ins_reg <= 1'b0;
            out_tpid_reg <= `VST_CUST_TPID;
            svc_vid_reg <= {`VST_VID_W{1'b0}};
            svc_pri_reg <= {`VST_PRI_W{1'b0}};
            crc_reg <= `VST_CRC_INIT;
            fcs_cnt_reg <= 2'h0;
            in_ready_reg <= 1'b0;
        end else begin
            state_reg <= state_next;
            in_ready_reg <= (state_next == S_CAP) || (state_next == S_DROP) || (state_next == S_BODY && body_room);
            // header capture, runt frames end in the capture state and vanish
            if (state_reg == S_CAP && in_take) begin
                hdr[cap_cnt_reg] <= in_data;
                hdr_last_reg <= in_last;
                cap_cnt_reg <= (in_last || cap_cnt_reg == `VST_HDR_LEN - 1) ? 5'h00 : cap_cnt_reg + 1'b1;
            end
            if (state_reg == S_DECIDE) begin
                // tunnel egress inserts, other egress roles insert no service tag
                ins_reg <= (out_role == `VST_ROLE_TUNNEL);
                keep_reg <= strip ? `VST_INNER_OFS : `VST_SA_END;
                emit_len_reg <= `VST_HDR_OUT_BASE - (strip ? `VST_TAG_LEN : 5'h00)
                    + ((out_role == `VST_ROLE_TUNNEL) ? `VST_TAG_LEN : 5'h00);
                out_tpid_reg <= out_tpid;
                svc_vid_reg <= key_vid_c;
                svc_pri_reg <= key_pri_c;
                emit_pos_reg <= 5'h00;
                crc_reg <= `VST_CRC_INIT;
                fcs_cnt_reg <= 2'h0;
            end
            // checksum runs over every rebuilt byte ahead of the check sequence
            if (wr_go && state_reg != S_FCS) begin
                crc_reg <= vst_crc_byte(crc_reg, wr_byte_c);
            end
            if (wr_go && state_reg == S_EMIT) begin
                emit_pos_reg <= emit_pos_reg + 1'b1;
            end
            if (wr_go && state_reg == S_FCS) begin
                fcs_cnt_reg <= fcs_cnt_reg + 1'b1;
            end
        end
    end

    // ----------------------------------------------------------------
    // forwarding key and drop report
    // ----------------------------------------------------------------
    // one pulse per classified frame, key is address plus service or customer vid
    always @(posedge clk) begin
        if (reset) begin
            fwd_valid_reg <= 1'b0;
            fwd_da_reg <= 48'h0000_0000_0000;
            fwd_vid_reg <= {`VST_VID_W{1'b0}};
            fwd_pri_reg <= {`VST_PRI_W{1'b0}};
            fwd_double_reg <= 1'b0;
            drop_reg <= 1'b0;
        end else begin
            fwd_valid_reg <= (state_reg == S_DECIDE) && !drop_c;
            drop_reg <= (state_reg == S_DECIDE) && drop_c;
            if (state_reg == S_DECIDE) begin
                fwd_da_reg <= {hdr[0], hdr[1], hdr[2], hdr[3], hdr[4], hdr[5]};
                fwd_vid_reg <= key_vid_c;
                fwd_pri_reg <= key_pri_c;
                fwd_double_reg <= stacked;
            end
        end
    end

    assign in_ready = in_ready_reg;
    assign fwd_valid = fwd_valid_reg;
    assign fwd_da = fwd_da_reg;
    assign fwd_vid = fwd_vid_reg;
    assign fwd_pri = fwd_pri_reg;
    assign fwd_double = fwd_double_reg;
    assign drop_pulse = drop_reg;
endmodule

/* bench/vst_tagger_props.sv */
// port assertions for the vlan stacking tagger
`timescale 1ns/1ps
module vst_props (
    input wire clk,
    input wire reset,
    input wire [1:0] in_role,
    input wire [11:0] service_vlan_id,
    input wire egress_member,
    input wire in_ready,
    input wire [7:0] out_data,
    input wire out_valid,
    input wire out_ready,
    input wire fwd_valid,
    input wire [11:0] fwd_vid,
    input wire fwd_double,
    input wire drop_pulse
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (reset);
    // a stalled byte stays put until the sink takes it
    sequence s_stall; out_valid && !out_ready; endsequence
    sequence s_held; out_valid && $stable(out_data); endsequence
    chk_out_hold: assert property (s_stall |=> s_held) else $error("byte not held");
    chk_fwd_pulse: assert property (fwd_valid |=> !fwd_valid) else $error("key pulse too long");
    chk_drop_pulse: assert property (drop_pulse |=> !drop_pulse) else $error("drop pulse too long");
    chk_fwd_or_drop: assert property (!(fwd_valid && drop_pulse)) else $error("kept and dropped");
    chk_reset_quiet: assert property (disable iff (1'b0) reset |=> !in_ready && !out_valid && !fwd_valid)
        else $error("busy after reset");
    chk_double_role: assert property (fwd_valid |-> fwd_double == (in_role == 2'h1 || in_role == 2'h2))
        else $error("stacked flag wrong");
    chk_access_vid: assert property (fwd_valid && in_role == 2'h1 |-> fwd_vid == service_vlan_id)
        else $error("access key not service vid");
    chk_member_gate: assert property (fwd_valid |-> $past(egress_member)) else $error("non member kept");
endmodule
bind vst_tagger vst_props u_vst_props (.clk(clk), .reset(reset), .in_role(in_role), .service_vlan_id(service_vlan_id),
    .egress_member(egress_member), .in_ready(in_ready), .out_data(out_data), .out_valid(out_valid),
    .out_ready(out_ready), .fwd_valid(fwd_valid), .fwd_vid(fwd_vid), .fwd_double(fwd_double), .drop_pulse(drop_pulse));

/* bench/vst_sink.sv */
// far side sink: long stalls fill the fifo, random gaps otherwise
`timescale 1ns/1ps
module vst_sink (
    input wire clk, // core clock
    output logic out_ready = 1'b0 // sink takes byte
);
    logic [5:0] phase_reg = 6'h00;
    // ready only in the upper half of each 64 cycles
    always @(negedge clk) begin
        phase_reg <= phase_reg + 6'h01;
        out_ready <= phase_reg[5] && ($urandom % 4 != 0);
    end
endmodule

/* bench/tb.sv */
// self-checking bench for the vlan stacking tagger
`timescale 1ns/1ps
`include "vst_consts.vh"
module tb;
    logic clk = 1'b0, reset = 1'b1, tpid_wr = 1'b0, egress_member = 1'b1, in_valid = 1'b0, in_last = 1'b0;
    logic [1:0] in_role = 2'h0, out_role = 2'h0;
    logic [2:0] service_pri = 3'h0;
    logic [11:0] service_vlan_id = 12'h000;
    logic [7:0] in_data = 8'h00, fr [0:51], ex [0:55];
    wire in_ready, out_valid, out_last, out_ready, fwd_valid, fwd_double, drop_pulse;
    wire [7:0] out_data;
    wire [11:0] fwd_vid;
    wire [47:0] fwd_da;
    wire [2:0] fwd_pri;
    logic [8:0] q [$];
    logic [62:0] fq [$];
    int n_mismatch = 0, n_checks = 0, n_drop = 0;
    always #5 clk = ~clk;
    vst_tagger u_vst_tagger (.clk(clk), .reset(reset), .in_role(in_role), .out_role(out_role), .in_tpid_index(3'h2),
        .out_tpid_index(3'h2), .port_vid(12'h005), .service_vlan_id(service_vlan_id), .service_pri(service_pri),
        .egress_member(egress_member), .tpid_wr(tpid_wr), .tpid_wr_index(3'h2), .tpid_wr_value(16'h9100),
        .in_data(in_data), .in_valid(in_valid), .in_last(in_last), .in_ready(in_ready), .out_data(out_data),
        .out_valid(out_valid), .out_last(out_last), .out_ready(out_ready), .fwd_valid(fwd_valid), .fwd_da(fwd_da),
        .fwd_vid(fwd_vid), .fwd_pri(fwd_pri), .fwd_double(fwd_double), .drop_pulse(drop_pulse));
    vst_sink u_vst_sink (.clk(clk), .out_ready(out_ready));
    task check(input [63:0] seen, input [63:0] want, input string what);
        n_checks++;
        if (seen !== want) begin
            n_mismatch++;
            $display("wrong value %s expected %h seen %h", what, want, seen);
        end
    endtask
    task summarize;
        $display("checks %0d mismatches %0d", n_checks, n_mismatch);
        if (n_mismatch == 0 && n_checks > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask
    task drain;
        for (int w = 0; w < 3000 && q.size() > 0; w++) @(negedge clk);
        if (q.size() > 0) drain_fail();
    endtask
    // build a frame, note expected bytes and key, then stream it in
    task run(input [1:0] ir, orl, input [31:0] t1, t2, input strip, ins, drop, input [11:0] fv);
        logic [31:0] crc;
        int n;
        drain();
        in_role = ir;
        out_role = orl;
        service_vlan_id = $urandom;
        service_pri = $urandom;
        for (int k = 0; k < 52; k++) fr[k] = $urandom;
        {fr[12], fr[13], fr[14], fr[15], fr[16], fr[17], fr[18], fr[19]} = {t1, t2};
        n = 0;
        crc = 32'hffff_ffff;
        for (int k = 0; k < 52; k++) begin
            if (k == 12 && ins) begin
                {ex[12], ex[13], ex[14], ex[15]} = {16'h9100, service_pri, 1'b0, service_vlan_id};
                n = 16;
            end
            if (k < 12 || k > 15 || !strip) ex[n++] = fr[k];
        end
        for (int k = 0; k < n; k++) begin
            crc = crc ^ ex[k];
            for (int b = 0; b < 8; b++) crc = crc[0] ? (crc >> 1) ^ 32'hedb8_8320 : crc >> 1;
            if (!drop) q.push_back({1'b0, ex[k]});
        end
        crc = ~crc;
        for (int k = 0; k < 4 && !drop; k++) q.push_back({k == 3, crc[8 * k +: 8]});
        if (!drop) fq.push_back({fr[0], fr[1], fr[2], fr[3], fr[4], fr[5],
            (fv != 12'hfff && (t1[31:16] == 16'h8100 || t1[31:16] == 16'h9100)) ? t1[15:13] : service_pri,
            fv == 12'hfff ? service_vlan_id : fv});
        for (int k = 0; k < 52; k++) begin
            in_valid = 1'b1;
            in_data = fr[k];
            in_last = (k == 51);
            for (int w = 0; w < 500 && in_ready !== 1'b1; w++) @(negedge clk);
            if (in_ready !== 1'b1) drain_fail();
            @(negedge clk);
        end
        in_valid = 1'b0;
        in_last = 1'b0;
        @(negedge clk);
    endtask
    task drain_fail;
        n_mismatch++;
        summarize();
    endtask
    // take the oldest note whenever the sink takes a byte or a forwarding key appears
    always @(posedge clk) begin
        if (out_valid && out_ready && q.size() == 0) check(out_data, 16'hffff, "extra byte");
        else if (out_valid && out_ready) check({out_last, out_data}, q.pop_front(), "out byte");
        if (fwd_valid)
            check({fwd_da, fwd_pri, fwd_vid}, fq.size() > 0 ? fq.pop_front() : 64'hffff_ffff_ffff_ffff, "fwd key");
        if (drop_pulse) n_drop++;
    end
    initial begin
        void'($urandom(32'h291e));
        repeat (8) @(negedge clk);
        reset = 1'b0;
        tpid_wr = 1'b1;
        @(negedge clk);
        tpid_wr = 1'b0;
        run(`VST_ROLE_NORMAL, `VST_ROLE_NORMAL, 32'h0800_1234, 32'h5678_9abc, 0, 0, 0, 12'h005);
        run(`VST_ROLE_NORMAL, `VST_ROLE_NORMAL, 32'h8100_e00f, 32'h0800_0000, 0, 0, 0, 12'h00f);
        run(`VST_ROLE_ACCESS, `VST_ROLE_TUNNEL, 32'h8100_605a, 32'h0800_0000, 0, 1, 0, 12'hfff);
        run(`VST_ROLE_TUNNEL, `VST_ROLE_ACCESS, 32'h9100_a0c8, 32'h8100_2011, 1, 0, 0, 12'h0c8);
        run(`VST_ROLE_TUNNEL, `VST_ROLE_TUNNEL, 32'h0800_1111, 32'h2222_3333, 0, 1, 0, 12'hfff);
        run(`VST_ROLE_NORMAL, `VST_ROLE_NORMAL, 32'h8100_0001, 32'h8100_0002, 0, 0, 1, 12'h000);
        run(`VST_ROLE_ACCESS, `VST_ROLE_TUNNEL, 32'h8100_0001, 32'h8100_0002, 0, 0, 1, 12'h000);
        egress_member = 1'b0;
        run(`VST_ROLE_NORMAL, `VST_ROLE_NORMAL, 32'h0800_4444, 32'h5555_6666, 0, 0, 1, 12'h000);
        egress_member = 1'b1;
        drain();
        repeat (40) @(negedge clk);
        check(fq.size(), 0, "keys left");
        check(n_drop[15:0], 16'h0003, "drops");
        summarize();
    end
endmodule
